// ### cms_console.sv
// Console model: drives the console pins and sends key codes over APB.
// Assumes a slave on pclk that answers each access with pready.
`timescale 1ns/100ps
`default_nettype none
module cms_console
(
    input  wire logic            pclk,
    input  wire logic            pready,
    output cms_pkg::cms_periph_t periph_kind,
    output cms_pkg::cms_mode_t   mode_selector,
    output logic                 psel,
    output logic                 penable,
    output logic                 pwrite,
    output logic [7:0]           paddr,
    output logic [31:0]          pwdata
);
    import cms_pkg::*;
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        periph_kind   = CMS_PERIPH_NONE;
        mode_selector = CMS_MODE_PROGRAM;
    end
    task automatic pins(input cms_periph_t k, input cms_mode_t s);
        @(posedge pclk);
        periph_kind   <= k;
        mode_selector <= s;
    endtask
    // Released address and data lines show the inverse, so stale values cannot pass.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 64)
        begin
            n++;
            @(posedge pclk);
        end
        psel    <= 1'h0;
        penable <= 1'h0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
    task automatic key(input logic [7:0] k);
        xfer(1'h1, CMS_A_KEY, {24'h00_0000, k});
    endtask
    task automatic unlock();
        key(CMS_KEY_CLEAR);
        key(CMS_KEY_MONITOR);
    endtask
endmodule
`default_nettype wire

// ### cms_ctrl.sv
// Controller mode, password, buzzer, memory clear, I/O table and errors.
// Assumes APB on pclk; straps and switches are synchronous to pclk.
//
// Operation
// - No peripheral at power-up: enter RUN mode.
// - Console at power-up: adopt the console mode selector.
// - Other peripheral at power-up: switch OFF gives PROGRAM, ON gives RUN.
// - Attaching a peripheral when powered keeps the current mode.
// - Detaching a peripheral keeps the current mode.
// - No peripheral in RUN: run-permit level starts and stops execution.
// - Password required at power-up or console attach; blocks programming.
// - Clear then monitor key grants access and adopts selector mode.
// - Selector changes honoured only after password accepted.
// - Right after password or mode change, shift then 1 toggles key beep.
// - Buzzer sounds on operational errors regardless of key beep enable.
// - Memory clear erases all zones; program only if writable and enabled.
// - Memory clear refused outside PROGRAM mode.
// - Keeping holding also keeps second zone; counter key keeps timer zone.
// - Partial clear keeps program below start address, clears from it on.
// - Table registration records mounted units, clears I/O, PROGRAM only.
// - Units differing from table raise mismatch; new table clears it.
// - With no table registered mismatch error never raised.
// - Clear, prefix, monitor shows first error; further monitor shows next.
// - Errors readable in any mode, deleted only in PROGRAM mode.
// - Check key reports first mismatch, each further press the next.
// - Language switch chooses message language; OFF means English.
// - In RUN mode console data changes refused, monitoring allowed.
//
// Our own choices: the address map and the APB register port.

`timescale 1ns/100ps
`default_nettype none

module cms_ctrl
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire cms_pkg::cms_periph_t   periph_kind,
    input  wire cms_pkg::cms_mode_t     mode_selector,
    input  wire logic                   initial_mode_on,
    input  wire logic                   run_permit,
    input  wire logic                   lang_switch,
    input  wire logic                   mem_writable,
    input  wire logic                   op_error,
    input  wire logic [7:0]             mounted_units,
    output cms_pkg::cms_mode_t          mode,
    output logic                        executing,
    output logic                        locked,
    output logic                        key_beep_indicator,
    output logic                        buzzer,
    output logic                        lang_english,
    output logic [5:0]                  clear_zones,
    output logic [15:0]                 clear_from,
    output logic                        clear_pulse,
    output logic                        io_clear_pulse,
    output logic                        io_mismatch_error
);
    import cms_pkg::*;

    cms_mode_t   mode_r;
    cms_periph_t periph_r;
    cms_seq_t    seq_r;
    logic        init_done_r;
    logic        locked_r;
    logic        beep_en_r;
    logic        beep_win_r;
    logic        buzz_r;
    logic        exec_r;
    logic        lang_r;
    logic        table_valid_r;
    logic [7:0]  table_r;
    logic        mism_r;
    logic [5:0]  zones_r;
    logic [15:0] from_r;
    logic        clr_p_r;
    logic        io_p_r;
    logic [2:0]  chk_idx_r;
    logic [2:0]  chk_rep_r;
    logic        chk_ok_r;
    logic [7:0]  err_q_r [CMS_ERRS];
    logic [3:0]  err_cnt_r;
    logic        err_shown_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    logic        wr_acc;
    logic        rd_acc;
    logic        key_wr;
    logic        cmd_wr;
    logic        err_push;
    logic        err_pop;
    logic [7:0]  key;

    // The bus answers in the access cycle, so every transfer is two cycles.
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign key     = pwdata[7:0];
    assign key_wr  = wr_acc && (paddr == CMS_A_KEY);
    assign cmd_wr  = wr_acc && (paddr == CMS_A_CMD);
    assign err_push = wr_acc && (paddr == CMS_A_ERRIN)
                      && (err_cnt_r != 4'(CMS_ERRS));

    function automatic logic is_key(input logic [7:0] k, input logic [7:0] c);
        return key_wr && (k == c);
    endfunction

    // Mode start-up from straps, then password gated selector tracking.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r      <= CMS_MODE_PROGRAM;
            periph_r    <= CMS_PERIPH_NONE;
            init_done_r <= 1'b0;
            locked_r    <= 1'b1;
        end
        else if (!init_done_r)
        begin
            init_done_r <= 1'b1;
            periph_r    <= periph_kind;
            locked_r    <= 1'b1;
            unique case (periph_kind)
                CMS_PERIPH_NONE:    mode_r <= CMS_MODE_RUN;
                CMS_PERIPH_CONSOLE: mode_r <= mode_selector;
                default:
                    mode_r <= initial_mode_on ? CMS_MODE_RUN
                                              : CMS_MODE_PROGRAM;
            endcase
        end
        else
        begin
            periph_r <= periph_kind;
            if (periph_kind == CMS_PERIPH_CONSOLE
                && periph_r != CMS_PERIPH_CONSOLE)
                locked_r <= 1'b1;
            else if (locked_r && seq_r == CMS_SEQ_CLR
                     && is_key(key, CMS_KEY_MONITOR))
            begin
                locked_r <= 1'b0;
                mode_r   <= mode_selector;
            end
            else if (!locked_r && periph_kind == CMS_PERIPH_CONSOLE)
                mode_r <= mode_selector;
        end
    end

    // Key sequence tracker shared by password, buzzer and error display.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seq_r <= CMS_SEQ_IDLE;
        else if (key_wr)
        begin
            unique case (key)
                CMS_KEY_CLEAR:  seq_r <= CMS_SEQ_CLR;
                CMS_KEY_PREFIX: seq_r <= (seq_r == CMS_SEQ_CLR)
                                         ? CMS_SEQ_CLRFUN : CMS_SEQ_IDLE;
                CMS_KEY_SHIFT:  seq_r <= CMS_SEQ_SHIFT;
                CMS_KEY_MONITOR:
                    seq_r <= (seq_r == CMS_SEQ_CLRFUN
                              || seq_r == CMS_SEQ_ERRSHW)
                             ? CMS_SEQ_ERRSHW : CMS_SEQ_IDLE;
                default:        seq_r <= CMS_SEQ_IDLE;
            endcase
        end
    end

    // Key beep window opens on unlock or mode change and closes on other keys.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            beep_en_r  <= 1'b1;
            beep_win_r <= 1'b0;
            buzz_r     <= 1'b0;
        end
        else
        begin
            if (!locked_r && ($changed(mode_r) || $fell(locked_r)))
                beep_win_r <= 1'b1;
            else if (key_wr && key != CMS_KEY_SHIFT)
                beep_win_r <= 1'b0;
            if (beep_win_r && seq_r == CMS_SEQ_SHIFT
                && is_key(key, CMS_KEY_DIGIT1))
                beep_en_r <= !beep_en_r;
            buzz_r <= op_error || (beep_en_r && key_wr);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exec_r <= 1'b0;
            lang_r <= 1'b1;
        end
        else
        begin
            exec_r <= (mode_r == CMS_MODE_RUN && run_permit)
                      || mode_r == CMS_MODE_MONITOR;
            lang_r <= !lang_switch;
        end
    end

    // Memory clear and table registration commands.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zones_r       <= '0;
            from_r        <= '0;
            clr_p_r       <= 1'b0;
            io_p_r        <= 1'b0;
            table_valid_r <= 1'b0;
            table_r       <= '0;
        end
        else
        begin
            clr_p_r <= 1'b0;
            io_p_r  <= 1'b0;
            if (wr_acc && paddr == CMS_A_CLRADDR)
                from_r <= pwdata[CMS_PADDR_W-1:0];
            if (cmd_wr && pwdata[CMS_C_CLEAR] && !locked_r
                && mode_r == CMS_MODE_PROGRAM)
            begin
                zones_r[CMS_Z_PROG] <= mem_writable;
                zones_r[CMS_Z_IO]   <= 1'b1;
                zones_r[CMS_Z_HOLD] <= !(pwdata[CMS_C_PARTIAL]
                                         && pwdata[CMS_C_KEEPHR]);
                zones_r[CMS_Z_SEC]  <= !(pwdata[CMS_C_PARTIAL]
                                         && pwdata[CMS_C_KEEPHR]);
                zones_r[CMS_Z_TC]   <= !(pwdata[CMS_C_PARTIAL]
                                         && pwdata[CMS_C_KEEPTC]);
                zones_r[CMS_Z_DM]   <= !(pwdata[CMS_C_PARTIAL]
                                         && pwdata[CMS_C_KEEPDM]);
                if (!pwdata[CMS_C_PARTIAL])
                    from_r <= '0;
                clr_p_r <= 1'b1;
            end
            if (cmd_wr && pwdata[CMS_C_REGTAB] && !locked_r
                && mode_r == CMS_MODE_PROGRAM)
            begin
                table_r       <= mounted_units;
                table_valid_r <= 1'b1;
                io_p_r        <= 1'b1;
            end
        end
    end

    // Mismatch flag and check-key walk over table slots.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mism_r    <= 1'b0;
            // The walk starts one slot before zero so slot zero is seen first.
            chk_idx_r <= '1;
            chk_rep_r <= '0;
            chk_ok_r  <= 1'b0;
        end
        else
        begin
            mism_r <= table_valid_r && (table_r != mounted_units)
                      && !io_p_r;
            // A new table restarts the walk at slot zero.
            if (io_p_r)
                chk_idx_r <= '1;
            if (is_key(key, CMS_KEY_CHECK) && table_valid_r)
            begin
                chk_ok_r <= 1'b0;
                for (int i = CMS_SLOTS; i >= 1; i--)
                begin
                    if (table_r[3'(chk_idx_r + 3'(i))]
                        != mounted_units[3'(chk_idx_r + 3'(i))])
                    begin
                        chk_rep_r <= 3'(chk_idx_r + 3'(i));
                        chk_idx_r <= 3'(chk_idx_r + 3'(i));
                        chk_ok_r  <= 1'b1;
                    end
                end
            end
        end
    end

    assign err_pop = err_shown_r && is_key(key, CMS_KEY_MONITOR)
                     && seq_r == CMS_SEQ_ERRSHW
                     && mode_r == CMS_MODE_PROGRAM
                     && err_cnt_r != 4'h0;

    // Error message store, oldest first.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_cnt_r   <= '0;
            err_shown_r <= 1'b0;
            for (int i = 0; i < CMS_ERRS; i++)
                err_q_r[i] <= '0;
        end
        else
        begin
            if (seq_r == CMS_SEQ_CLRFUN && is_key(key, CMS_KEY_MONITOR))
                err_shown_r <= 1'b1;
            else if (key_wr && key != CMS_KEY_MONITOR)
                err_shown_r <= 1'b0;
            if (err_pop)
            begin
                for (int i = 0; i < CMS_ERRS - 1; i++)
                    err_q_r[i] <= err_q_r[i+1];
                err_cnt_r <= err_cnt_r - 4'h1;
            end
            else if (err_push)
            begin
                err_q_r[3'(err_cnt_r)] <= pwdata[7:0];
                err_cnt_r <= err_cnt_r + 4'h1;
            end
        end
    end

    // APB read path and data-write refusal.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= CMS_ZERO32;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= psel && !penable;
            pslverr_r <= 1'b0;
            prdata_r  <= CMS_ZERO32;
            if (psel && !penable)
            begin
                pslverr_r <= pwrite && paddr == CMS_A_CMD
                             && pwdata[CMS_C_DATAWR]
                             && (mode_r == CMS_MODE_RUN || locked_r);
                if (!pwrite)
                    unique case (paddr)
                        CMS_A_STATUS: prdata_r <= {22'h00_0000, mism_r,
                            table_valid_r, lang_r, beep_en_r, locked_r,
                            exec_r, 2'(periph_r), 2'(mode_r)};
                        CMS_A_ERROUT: prdata_r <= {20'h0_0000,
                            err_cnt_r, err_q_r[0]};
                        CMS_A_MOUNT:  prdata_r <= {24'h00_0000,
                            mounted_units};
                        CMS_A_TABLE:  prdata_r <= {24'h00_0000, table_r};
                        CMS_A_MISS:   prdata_r <= {28'h000_0000,
                            chk_ok_r, chk_rep_r};
                        CMS_A_CLRADDR: prdata_r <= {16'h0000, from_r};
                        default:      prdata_r <= CMS_ZERO32;
                    endcase
            end
        end
    end

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign mode               = mode_r;
    assign executing          = exec_r;
    assign locked             = locked_r;
    assign key_beep_indicator = beep_en_r;
    assign buzzer             = buzz_r;
    assign lang_english       = lang_r;
    assign clear_zones        = zones_r;
    assign clear_from         = from_r;
    assign clear_pulse        = clr_p_r;
    assign io_clear_pulse     = io_p_r;
    assign io_mismatch_error  = mism_r;

    // Read-only helper logic.
    logic unused_rd;
    assign unused_rd = rd_acc;

    no_clear_outside_prog_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        clear_pulse |-> $past(mode_r) == CMS_MODE_PROGRAM)
        else $error("Memory clear outside PROGRAM mode.");

    no_mism_untabled_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !table_valid_r |-> ##1 !io_mismatch_error)
        else $error("Mismatch raised without a table.");

    sequence unlock_s;
        seq_r == CMS_SEQ_CLR && locked_r && key_wr
        && key == CMS_KEY_MONITOR;
    endsequence
    password_unlock_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        (init_done_r && periph_r == periph_kind) and unlock_s
        |=> !locked_r)
        else $error("Password did not unlock.");

    mode_held_locked_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        init_done_r && $past(init_done_r) && locked_r && $past(locked_r)
        |-> $stable(mode_r))
        else $error("Mode moved while locked.");

    run_permit_exec_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_r == CMS_MODE_RUN && $stable(mode_r)
        |=> executing == $past(run_permit))
        else $error("Execution does not follow run permit.");

    error_buzz_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        op_error |=> buzzer)
        else $error("Error did not sound buzzer.");

    hold_keeps_sec_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        clear_pulse |-> clear_zones[CMS_Z_HOLD]
                        == clear_zones[CMS_Z_SEC])
        else $error("Holding and second zone clear differ.");

    prog_clear_writable_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        clear_pulse && !$past(mem_writable)
        |-> !clear_zones[CMS_Z_PROG])
        else $error("Protected program memory cleared.");

    english_lang_a: assert property (@(posedge pclk)
        disable iff (!presetn)
        !lang_switch |=> lang_english)
        else $error("Language switch OFF not English.");
endmodule

`default_nettype wire

// ### cms_pkg.sv
// Package for the controller mode and setup block.
// Assumes a single 200 MHz clock domain and an APB register port.
package cms_pkg;
    typedef enum logic [1:0]
    {
        CMS_MODE_PROGRAM = 2'b00,
        CMS_MODE_MONITOR = 2'b01,
        CMS_MODE_RUN     = 2'b10
    } cms_mode_t;

    typedef enum logic [1:0]
    {
        CMS_PERIPH_NONE    = 2'b00,
        CMS_PERIPH_CONSOLE = 2'b01,
        CMS_PERIPH_OTHER   = 2'b10
    } cms_periph_t;

    typedef enum logic [2:0]
    {
        CMS_SEQ_IDLE   = 3'b000,
        CMS_SEQ_CLR    = 3'b001,
        CMS_SEQ_CLRFUN = 3'b010,
        CMS_SEQ_SHIFT  = 3'b011,
        CMS_SEQ_ERRSHW = 3'b100
    } cms_seq_t;

    // Key codes written by the console side into the key register.
    localparam logic [7:0] CMS_KEY_CLEAR   = 8'h01;
    localparam logic [7:0] CMS_KEY_MONITOR = 8'h02;
    localparam logic [7:0] CMS_KEY_PREFIX  = 8'h03;
    localparam logic [7:0] CMS_KEY_SHIFT   = 8'h04;
    localparam logic [7:0] CMS_KEY_DIGIT1  = 8'h05;
    localparam logic [7:0] CMS_KEY_CHECK   = 8'h06;

    // Register byte addresses.
    localparam logic [7:0] CMS_A_KEY     = 8'h00;
    localparam logic [7:0] CMS_A_CMD     = 8'h04;
    localparam logic [7:0] CMS_A_STATUS  = 8'h08;
    localparam logic [7:0] CMS_A_ERRIN   = 8'h0C;
    localparam logic [7:0] CMS_A_ERROUT  = 8'h10;
    localparam logic [7:0] CMS_A_MOUNT   = 8'h14;
    localparam logic [7:0] CMS_A_TABLE   = 8'h18;
    localparam logic [7:0] CMS_A_MISS    = 8'h1C;
    localparam logic [7:0] CMS_A_CLRADDR = 8'h20;

    // Command register bits.
    localparam int CMS_C_CLEAR   = 0;
    localparam int CMS_C_PARTIAL = 1;
    localparam int CMS_C_KEEPHR  = 2;
    localparam int CMS_C_KEEPTC  = 3;
    localparam int CMS_C_KEEPDM  = 4;
    localparam int CMS_C_REGTAB  = 5;
    localparam int CMS_C_DATAWR  = 6;

    // Clear-zone mask bits.
    localparam int CMS_Z_PROG = 0;
    localparam int CMS_Z_IO   = 1;
    localparam int CMS_Z_HOLD = 2;
    localparam int CMS_Z_SEC  = 3;
    localparam int CMS_Z_DM   = 4;
    localparam int CMS_Z_TC   = 5;
    localparam int CMS_ZONES  = 6;

    localparam int CMS_SLOTS   = 8;
    localparam int CMS_ERRS    = 8;
    localparam int CMS_PADDR_W = 16;
    localparam logic [31:0] CMS_ZERO32 = 32'h0000_0000;
endpackage

// ### tb_top.sv
// Testbench: APB through the console model, queued expectations.
// Assumes zero-wait APB and registered outputs of cms_ctrl.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cms_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, mounted_units;
    logic [31:0] pwdata, prdata, m;
    cms_periph_t periph_kind;
    cms_mode_t   mode_selector, mode;
    logic        initial_mode_on, run_permit, lang_switch, mem_writable;
    logic        op_error, executing, locked, key_beep_indicator, buzzer;
    logic        lang_english, clear_pulse, io_clear_pulse, io_mismatch_error;
    logic [5:0]  clear_zones;
    logic [15:0] clear_from;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [21:0] clr_q[$];
    logic [32:0] e;
    logic [31:0] k;
    int          io_exp, err_count, num_checks, seed;
    cms_ctrl dut_u
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .periph_kind, .mode_selector, .initial_mode_on,
        .run_permit, .lang_switch, .mem_writable, .op_error, .mounted_units,
        .mode, .executing, .locked, .key_beep_indicator, .buzzer,
        .lang_english, .clear_zones, .clear_from, .clear_pulse,
        .io_clear_pulse, .io_mismatch_error
    );
    cms_console con_u
    (
        .pclk, .pready, .periph_kind, .mode_selector, .psel, .penable,
        .pwrite, .paddr, .pwdata
    );
    initial
    begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic fail(input string s, input logic [32:0] x, y);
        err_count++;
        $display("[FAIL] %s expected %h seen %h", s, x, y);
    endtask
    task automatic chk(input string s, input logic [32:0] x, y);
        num_checks++;
        if (x !== y)
            fail(s, x, y);
    endtask
    task automatic final_report();
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Every answer or pulse consumes the oldest note of its kind.
    always @(posedge pclk)
    begin
        if (pready === 1'h1 && exp_q.size() == 0)
            fail("pready", 1'h0, 1'h1);
        else if (pready === 1'h1)
        begin
            e = exp_q.pop_front();
            k = msk_q.pop_front();
            chk("apb", {e[32], e[31:0] & k}, {pslverr, prdata & k});
        end
        if (clear_pulse === 1'h1 && clr_q.size() == 0)
            fail("clear_pulse", 1'h0, 1'h1);
        else if (clear_pulse === 1'h1)
            chk("clear", clr_q.pop_front(), {clear_from, clear_zones});
        if (io_clear_pulse === 1'h1)
        begin
            chk("io_clear", 1'h1, io_exp > 0);
            io_exp--;
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, msk);
        exp_q.push_back({1'h0, x});
        msk_q.push_back(msk);
        con_u.xfer(1'h0, a, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic s);
        exp_q.push_back({s, 32'h0000_0000});
        msk_q.push_back(32'h0000_0000);
        con_u.xfer(1'h1, a, d);
    endtask
    task automatic key(input logic [7:0] c);
        wr(CMS_A_KEY, {24'h00_0000, c}, 1'h0);
    endtask
    task automatic unlock();
        key(CMS_KEY_CLEAR);
        key(CMS_KEY_MONITOR);
    endtask
    task automatic clr(input logic [31:0] d, input logic [21:0] x);
        clr_q.push_back(x);
        wr(CMS_A_CMD, d, 1'h0);
        wt(3);
    endtask
    task automatic boot(input cms_periph_t p, input cms_mode_t s,
                        input logic on);
        presetn <= 1'h0;
        initial_mode_on <= on;
        con_u.pins(p, s);
        wt(7);
        presetn <= 1'h1;
        wt(3);
    endtask
    initial
    begin
        seed = 6;
        {err_count, num_checks, io_exp} = '0;
        {presetn, initial_mode_on, lang_switch, op_error} = '0;
        {run_permit, mem_writable} = 2'h3;
        mounted_units = 8'h00;
        boot(CMS_PERIPH_NONE, CMS_MODE_PROGRAM, 1'h0);
        chk("mode", CMS_MODE_RUN, mode);
        chk("executing", 1'h1, executing);
        chk("english", 1'h1, lang_english);
        run_permit <= 1'h0;
        lang_switch <= 1'h1;
        con_u.pins(CMS_PERIPH_CONSOLE, CMS_MODE_PROGRAM);
        wt(3);
        chk("executing", 1'h0, executing);
        chk("english", 1'h0, lang_english);
        chk("mode", CMS_MODE_RUN, mode);
        chk("locked", 1'h1, locked);
        unlock();
        wt(3);
        chk("mode", CMS_MODE_PROGRAM, mode);
        boot(CMS_PERIPH_CONSOLE, CMS_MODE_PROGRAM, 1'h0);
        chk("mode", CMS_MODE_PROGRAM, mode);
        con_u.pins(CMS_PERIPH_CONSOLE, CMS_MODE_RUN);
        wt(3);
        chk("mode", CMS_MODE_PROGRAM, mode);
        wr(CMS_A_CMD, 32'h0000_0001, 1'h0);
        con_u.pins(CMS_PERIPH_CONSOLE, CMS_MODE_PROGRAM);
        unlock();
        wt(3);
        chk("locked", 1'h0, locked);
        key(CMS_KEY_SHIFT);
        key(CMS_KEY_DIGIT1);
        op_error <= 1'h1;
        wt(3);
        chk("beep", 1'h0, key_beep_indicator);
        chk("buzzer", 1'h1, buzzer);
        op_error <= 1'h0;
        mem_writable <= 1'h0;
        clr(32'h0000_0001, 22'h3E);
        mem_writable <= 1'h1;
        clr(32'h0000_0001, 22'h3F);
        wr(CMS_A_CLRADDR, 32'h0000_007B, 1'h0);
        clr(32'h0000_0007, {16'h007B, 6'h33});
        clr(32'h0000_001B, {16'h007B, 6'h0F});
        m = $random(seed);
        mounted_units <= m[7:0];
        wt(3);
        chk("mismatch", 1'h0, io_mismatch_error);
        io_exp = 1;
        wr(CMS_A_CMD, 32'h0000_0020, 1'h0);
        rd(CMS_A_STATUS, 32'h0000_0100, 32'h0000_0300);
        mounted_units <= m[7:0] ^ 8'h05;
        wt(3);
        chk("mismatch", 1'h1, io_mismatch_error);
        key(CMS_KEY_CHECK);
        rd(CMS_A_MISS, 32'h0000_0008, 32'h0000_000F);
        key(CMS_KEY_CHECK);
        rd(CMS_A_MISS, 32'h0000_000A, 32'h0000_000F);
        io_exp = 1;
        wr(CMS_A_CMD, 32'h0000_0020, 1'h0);
        wt(3);
        chk("mismatch", 1'h0, io_mismatch_error);
        wr(CMS_A_ERRIN, {24'h00_0000, m[15:8]}, 1'h0);
        wr(CMS_A_ERRIN, {24'h00_0000, m[23:16]}, 1'h0);
        key(CMS_KEY_CLEAR);
        key(CMS_KEY_PREFIX);
        key(CMS_KEY_MONITOR);
        rd(CMS_A_ERROUT, {24'h00_0000, m[15:8]}, 32'h0000_00FF);
        key(CMS_KEY_MONITOR);
        rd(CMS_A_ERROUT, {20'h0_0001, m[23:16]}, 32'h0000_0FFF);
        rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
        con_u.pins(CMS_PERIPH_CONSOLE, CMS_MODE_RUN);
        wt(3);
        chk("mode", CMS_MODE_RUN, mode);
        wr(CMS_A_CMD, 32'h0000_0001, 1'h0);
        wr(CMS_A_CMD, 32'h0000_0040, 1'h1);
        rd(CMS_A_ERROUT, {24'h00_0000, m[23:16]}, 32'h0000_00FF);
        boot(CMS_PERIPH_OTHER, CMS_MODE_RUN, 1'h0);
        chk("mode", CMS_MODE_PROGRAM, mode);
        con_u.pins(CMS_PERIPH_NONE, CMS_MODE_RUN);
        wt(3);
        chk("mode", CMS_MODE_PROGRAM, mode);
        boot(CMS_PERIPH_OTHER, CMS_MODE_PROGRAM, 1'h1);
        chk("mode", CMS_MODE_RUN, mode);
        chk("pending", 1'h0, exp_q.size() + clr_q.size() + io_exp);
        final_report();
    end
    initial
    begin
        #50000;
        fail("watchdog", 1'h0, 1'h1);
        final_report();
    end
endmodule
`default_nettype wire
